// [inc/meter_irq_pkg.sv]
// constants, offsets and field positions for the metering event and interrupt block
// Contract
// - overvoltage sets bit 18, records phases 11:9
// - A rise then C rise sets bit 19
// - current magnitude mismatch over threshold sets bit 20
// - no neutral channel: mismatch bit reads zero
// - status bit 21 always reads one
// - status bit 22 always reads zero
// - current peak period end sets 23, captures peak
// - voltage peak period end sets 24, captures peak
// - status bits 31 to 25 read zero
// - mask 0: total active bit30 change interrupts
// - mask 1: fundamental active bit30 change interrupts
// - mask 2: total reactive bit30 change interrupts
// - mask 3: fundamental reactive bit30 change interrupts
// - mask 4: apparent energy bit30 change interrupts
// - mask 5: line cycle integration end interrupts
// - masks 6-8: phase active power sign change
// - mask 9: pulse one power sum sign change
// - absent measurement: mask writable, no effect
package meter_irq_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_IRQ_ENABLE_MASK_LOW    = 16'hE50A; // irq_enable_mask_low
  localparam logic [15:0] IDX_EVENT_STATUS_SECOND  = 16'hE520; // event_status_second
  localparam logic [15:0] IDX_STATUS0  = 16'hE521; // sticky energy and sign events
  localparam logic [15:0] IDX_MASK1    = 16'hE522; // enables for status bits 18..24
  localparam logic [15:0] IDX_PHSTAT   = 16'hE523; // phase_status_register
  localparam logic [15:0] IDX_THRESH   = 16'hE524; // mismatch_threshold
  localparam logic [15:0] IDX_ACCUMULATION_MODE_REGISTER  = 16'hE525; // accumulation_mode_register
  localparam logic [15:0] IDX_CURPEAK  = 16'hE526; // current_peak_register
  localparam logic [15:0] IDX_VOLTPEAK = 16'hE527; // voltage_peak_register
  // widths
  localparam int ADR_W  = 18; // byte address width
  localparam int DATA_W = 24; // measurement sample width
  // second status register, stored as bits 18..24
  localparam int STAT1_LSB = 18;
  localparam int STAT1_W   = 7;
  localparam int B_OVER    = 18; // overvoltage_flag
  localparam int B_SEQ     = 19; // phase_sequence_error_flag
  localparam int B_MIS     = 20; // current_mismatch_flag
  localparam int B_RES1    = 21; // reserved, reads one
  localparam int B_RES0    = 22; // reserved, reads zero
  localparam int B_CPEAK   = 23; // current_peak_period_done
  localparam int B_VOLTAGE_PEAK_REGISTER   = 24; // voltage_peak_period_done
  localparam logic [6:0] STAT1_LIVE = 7'h67; // bits that hold flags
  localparam logic [6:0] STAT1_ONES = 7'h08; // bits that read one
  // first mask register bits
  localparam int IRQ_ENABLE_MASK_LOW_W   = 10;
  localparam int M_TOT_ACT = 0; // total_active_half_full_en
  localparam int M_FUN_ACT = 1; // fund_active_half_full_en
  localparam int M_TOT_REA = 2; // total_reactive_half_full_en
  localparam int M_FUN_REA = 3; // fund_reactive_half_full_en
  localparam int M_APPAR   = 4; // apparent_half_full_en
  localparam int M_LINE    = 5; // line_cycle_done_en
  localparam int M_SIGN_A  = 6; // phase_a_active_sign_en, b and c follow
  localparam int M_PSUM1   = 9; // pulse1_sum_sign_en
  // other fields
  localparam int PH_LSB      = 9;  // overvoltage_phase_field
  localparam int ACC_SEL_BIT = 6;  // active_sign_source_select
  localparam int ACC_LINE    = 0;  // line accumulation mode enable
  localparam int PEAK_PH_LSB = 24; // peak phase field
  // reset values
  localparam logic [9:0]  IRQ_ENABLE_MASK_LOW_RST  = 10'h000;
  localparam logic [6:0]  MASK1_RST  = 7'h00;
  localparam logic [23:0] THRESH_RST = 24'h000000;
endpackage : meter_irq_pkg

// [inc/meas_if.sv]
// carrier between the event block and its two checkers
`timescale 1ns/1ps
interface meas_if;
  logic [2:0]         zx_rise;    // rising zero crossings, c b a
  logic               seq_err;    // one-cycle sequence error
  logic signed [23:0] sum_cur;    // summed_phase_current
  logic signed [23:0] neut_cur;   // neutral_current_sample
  logic [23:0]        thresh;     // mismatch_threshold
  logic               samp_valid; // new current samples
  logic               mismatch;   // one-cycle mismatch event
  // event block side
  modport src (output zx_rise, sum_cur, neut_cur, thresh, samp_valid,
               input seq_err, mismatch);
  // sequence checker side
  modport seq (input zx_rise, output seq_err);
  // magnitude comparator side
  modport cmp (input sum_cur, neut_cur, thresh, samp_valid, output mismatch);
endinterface : meas_if

// [rtl/seq_order_check.sv]
// phase rotation checker on rising voltage zero crossings
`timescale 1ns/1ps
module seq_order_check (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // crossings in, error out
  meas_if.seq      m
);
  typedef enum logic {WAIT_A, WAIT_BC} seq_st_t;
  typedef struct packed {
    seq_st_t st;  // waiting for a or for the next phase
    logic    err; // error pulse
  } seq_t;

  seq_t s;      // registered state
  seq_t next_s; // next state

  // next state: a re-arms, then b or c decides; b wins a tie
  always_comb begin
    next_s = s;
    next_s.err = 1'b0;
    unique case (s.st)
      WAIT_A: begin
        if (m.zx_rise[0]) begin
          next_s.st = WAIT_BC;
        end
      end
      WAIT_BC: begin
        if (m.zx_rise[0]) begin
          next_s.st = WAIT_BC; // fresh a restarts the window
        end else if (m.zx_rise[1]) begin
          next_s.st = WAIT_A; // correct rotation
        end else if (m.zx_rise[2]) begin
          next_s.st = WAIT_A;
          next_s.err = 1'b1;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{st: WAIT_A, err: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign m.seq_err = s.err;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // a then c gives an error in the next cycle
  seq_c_after_a_a: assert property (s.st == WAIT_BC && m.zx_rise == 3'h4 |=> s.err)
    else $error("c after a gave no sequence error");
  // no error without a c crossing one cycle before
  seq_err_cause_a: assert property (s.err |-> $past(m.zx_rise[2]) && !$past(m.zx_rise[1]))
    else $error("sequence error without c crossing");
  seq_err_c: cover property (s.st == WAIT_A ##1 s.st == WAIT_BC ##[1:20] s.err);
endmodule : seq_order_check

// [rtl/mismatch_cmp.sv]
// compares summed phase current and neutral current magnitudes
`timescale 1ns/1ps
module mismatch_cmp (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // samples in, event out
  meas_if.cmp      m
);
  typedef struct packed {
    logic mis; // mismatch pulse
  } cmp_t;

  cmp_t s;      // registered state
  cmp_t next_s; // next state
  logic signed [24:0] diff; // signed magnitude difference

  // magnitude of a signed sample; full scale negative still fits
  function automatic logic [23:0] mag(input logic signed [23:0] v);
    mag = v[23] ? 24'(-v) : 24'(v);
  endfunction : mag

  // difference of magnitudes compared with the threshold
  always_comb begin
    diff = $signed({1'b0, mag(m.sum_cur)}) - $signed({1'b0, mag(m.neut_cur)});
    next_s.mis = m.samp_valid && !diff[24] && (diff[23:0] > m.thresh);
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{mis: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign m.mismatch = s.mis;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // a pulse exactly one cycle after a sample over the threshold
  // widened sum form, independent of the subtraction used above
  mis_detect_a: assert property (s.mis == $past(m.samp_valid
    && ({1'b0, mag(m.sum_cur)} > {1'b0, mag(m.neut_cur)} + {1'b0, m.thresh})))
    else $error("mismatch pulse does not follow its sample");
endmodule : mismatch_cmp

// [rtl/meter_event_irq.sv]
// event status, interrupt mask and wishbone slave for the metering dsp
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
module meter_event_irq #(
  parameter bit HAS_NEUTRAL  = 1'b1, // neutral current channel fitted
  parameter bit HAS_FUND     = 1'b1, // fundamental measurements fitted
  parameter bit HAS_REACTIVE = 1'b1  // reactive measurements fitted
) (
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  // wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [17:0] WB_ADR_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // interrupt
  output logic             IRQ,
  // voltage events
  input  wire logic        OVERVOLT_EVT,
  input  wire logic [2:0]  OVERVOLT_PHASES,
  input  wire logic [2:0]  ZERO_CROSS_RISE,
  // current samples
  input  wire logic [23:0] SUM_CURRENT,
  input  wire logic [23:0] NEUTRAL_CURRENT,
  input  wire logic        CURRENT_SAMPLE_VALID,
  // peak detection
  input  wire logic        CUR_PEAK_DONE,
  input  wire logic [23:0] CUR_PEAK_VALUE,
  input  wire logic [2:0]  CUR_PEAK_PHASE,
  input  wire logic        VOLT_PEAK_DONE,
  input  wire logic [23:0] VOLT_PEAK_VALUE,
  input  wire logic [2:0]  VOLT_PEAK_PHASE,
  // energy and power
  input  wire logic [14:0] ENERGY_BIT30,
  input  wire logic        LINE_CYCLE_DONE,
  input  wire logic [2:0]  ACTIVE_SIGN_TOTAL,
  input  wire logic [2:0]  ACTIVE_SIGN_FUND,
  input  wire logic        PULSE1_SUM_SIGN
);
  // stored flag positions inside the second status register
  localparam int S_OVER  = meter_irq_pkg::B_OVER - meter_irq_pkg::STAT1_LSB;
  localparam int S_SEQ   = meter_irq_pkg::B_SEQ - meter_irq_pkg::STAT1_LSB;
  localparam int S_MIS   = meter_irq_pkg::B_MIS - meter_irq_pkg::STAT1_LSB;
  localparam int S_CPEAK = meter_irq_pkg::B_CPEAK - meter_irq_pkg::STAT1_LSB;
  localparam int S_VOLTAGE_PEAK_REGISTER = meter_irq_pkg::B_VOLTAGE_PEAK_REGISTER - meter_irq_pkg::STAT1_LSB;

  typedef struct packed {
    logic [9:0]  irq_enable_mask_low;     // irq_enable_mask_low
    logic [9:0]  stat0;     // sticky energy and sign events
    logic [6:0]  mask1;     // enables for bits 18..24
    logic [6:0]  stat1;     // event_status_second bits 18..24
    logic [2:0]  ov_phases; // overvoltage_phase_field
    logic [23:0] thresh;    // mismatch_threshold
    logic        sign_sel;  // active_sign_source_select
    logic        line_mode; // line accumulation mode
    logic [26:0] cpeak;     // current_peak_register
    logic [26:0] voltage_peak_register;     // voltage_peak_register
    logic [14:0] prev_b30;  // last seen energy bit 30
    logic [2:0]  prev_sign; // last seen phase power sign
    logic        prev_sum;  // last seen pulse one sum sign
    logic [31:0] dat;       // read data
    logic        ack;       // bus acknowledge
    logic        irq;       // interrupt level
    logic        st1_rd;    // answering a read of the second status register
  } evt_t;

  evt_t        s;      // registered state
  evt_t        next_s; // next state
  logic        go;     // new bus request this cycle
  logic        wr;     // write request
  logic [15:0] idx;    // word index
  logic [31:0] bm;     // byte lane mask
  logic [31:0] rd;     // read mux
  logic [9:0]  set0;   // events for the first status group
  logic [9:0]  clr0;   // write-one clears
  logic [6:0]  set1;   // events for the second status group
  logic [6:0]  clr1;   // write-one clears
  logic [4:0]  kind_on; // energy kinds present in this variant
  logic [2:0]  sign_now; // selected phase power sign
  logic [31:0] mask1_wr; // mask1 write merged into its byte lanes

  meas_if m (); // carrier to the checkers

  // feed the checkers
  assign m.zx_rise    = ZERO_CROSS_RISE;
  assign m.sum_cur    = SUM_CURRENT;
  assign m.neut_cur   = NEUTRAL_CURRENT;
  assign m.thresh     = s.thresh;
  assign m.samp_valid = CURRENT_SAMPLE_VALID;

  // phase rotation checker
  seq_order_check u_seq (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .m     (m)
  );

  // magnitude comparator
  mismatch_cmp u_cmp (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .m     (m)
  );

  // expand byte enables to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : lane_mask

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [31:0] msk);
    merge = (old & ~msk) | (wd & msk);
  endfunction : merge

  // absent kinds never raise an event, so their mask bits do nothing
  assign kind_on = {1'b1, HAS_REACTIVE & HAS_FUND, HAS_REACTIVE, HAS_FUND, 1'b1};
  // power sign source: total or fundamental
  assign sign_now = s.sign_sel ? ACTIVE_SIGN_FUND : ACTIVE_SIGN_TOTAL;
  // mask1 sits at bits 18..24, so merge at its bus position first
  assign mask1_wr = merge({7'h00, s.mask1, 18'h0}, WB_DAT_I, bm);

  // bus decode and read mux from the current state
  always_comb begin
    go  = WB_CYC_I && WB_STB_I && !s.ack;
    wr  = go && WB_WE_I;
    idx = WB_ADR_I[17:2];
    bm  = lane_mask(WB_SEL_I);
    rd  = 32'h0000_0000;
    case (idx)
      meter_irq_pkg::IDX_IRQ_ENABLE_MASK_LOW: begin
        rd[9:0] = s.irq_enable_mask_low;
      end
      meter_irq_pkg::IDX_EVENT_STATUS_SECOND: begin
        // reserved bits are forced, upper bits stay zero
        rd[meter_irq_pkg::STAT1_LSB +: meter_irq_pkg::STAT1_W] =
          (s.stat1 & meter_irq_pkg::STAT1_LIVE) | meter_irq_pkg::STAT1_ONES;
      end
      meter_irq_pkg::IDX_STATUS0: begin
        rd[9:0] = s.stat0;
      end
      meter_irq_pkg::IDX_MASK1: begin
        rd[meter_irq_pkg::STAT1_LSB +: meter_irq_pkg::STAT1_W] = s.mask1;
      end
      meter_irq_pkg::IDX_PHSTAT: begin
        rd[meter_irq_pkg::PH_LSB +: 3] = s.ov_phases;
      end
      meter_irq_pkg::IDX_THRESH: begin
        rd[23:0] = s.thresh;
      end
      meter_irq_pkg::IDX_ACCUMULATION_MODE_REGISTER: begin
        rd[meter_irq_pkg::ACC_SEL_BIT] = s.sign_sel;
        rd[meter_irq_pkg::ACC_LINE]    = s.line_mode;
      end
      meter_irq_pkg::IDX_CURPEAK: begin
        rd[26:0] = s.cpeak;
      end
      meter_irq_pkg::IDX_VOLTPEAK: begin
        rd[26:0] = s.voltage_peak_register;
      end
      default: begin
        rd = 32'h0000_0000; // unmapped reads zero, still acknowledged
      end
    endcase
  end

  // event detection, set has priority over a same-cycle clear
  always_comb begin
    set1 = 7'h00;
    set1[S_OVER]  = OVERVOLT_EVT;
    set1[S_SEQ]   = m.seq_err;
    set1[S_MIS]   = m.mismatch && HAS_NEUTRAL;
    set1[S_CPEAK] = CUR_PEAK_DONE;
    set1[S_VOLTAGE_PEAK_REGISTER] = VOLT_PEAK_DONE;
    set0 = 10'h000;
    // any of three phases toggling bit 30 of an accumulator kind
    for (int k = 0; k < 5; k++) begin
      set0[k] = kind_on[k] && |(ENERGY_BIT30[k*3 +: 3] ^ s.prev_b30[k*3 +: 3]);
    end
    set0[meter_irq_pkg::M_LINE] = LINE_CYCLE_DONE && s.line_mode;
    set0[meter_irq_pkg::M_SIGN_A +: 3] = sign_now ^ s.prev_sign;
    set0[meter_irq_pkg::M_PSUM1] = PULSE1_SUM_SIGN ^ s.prev_sum;
    clr0 = 10'h000;
    clr1 = 7'h00;
    if (wr && idx == meter_irq_pkg::IDX_STATUS0) begin
      clr0 = WB_DAT_I[9:0] & bm[9:0];
    end
    if (wr && idx == meter_irq_pkg::IDX_EVENT_STATUS_SECOND) begin
      clr1 = WB_DAT_I[meter_irq_pkg::STAT1_LSB +: meter_irq_pkg::STAT1_W]
           & bm[meter_irq_pkg::STAT1_LSB +: meter_irq_pkg::STAT1_W];
    end
  end

  // next state: registers, flags, history, bus answer, interrupt
  always_comb begin
    next_s = s;
    // writable registers honour byte lanes
    if (wr) begin
      case (idx)
        meter_irq_pkg::IDX_IRQ_ENABLE_MASK_LOW: begin
          next_s.irq_enable_mask_low = 10'(merge({22'h0, s.irq_enable_mask_low}, WB_DAT_I, bm));
        end
        meter_irq_pkg::IDX_MASK1: begin
          next_s.mask1 = mask1_wr[24:18];
        end
        meter_irq_pkg::IDX_THRESH: begin
          next_s.thresh = 24'(merge({8'h00, s.thresh}, WB_DAT_I, bm));
        end
        meter_irq_pkg::IDX_ACCUMULATION_MODE_REGISTER: begin
          if (WB_SEL_I[0]) begin
            next_s.sign_sel  = WB_DAT_I[meter_irq_pkg::ACC_SEL_BIT];
            next_s.line_mode = WB_DAT_I[meter_irq_pkg::ACC_LINE];
          end
        end
        default: begin
          next_s.dat = s.dat; // other writes store nothing here; status writes clear flags below
        end
      endcase
    end
    // sticky flags
    next_s.stat0 = (s.stat0 & ~clr0) | set0;
    next_s.stat1 = ((s.stat1 & ~clr1) | set1) & meter_irq_pkg::STAT1_LIVE;
    // phase field follows the overvoltage flag and clears with it
    next_s.ov_phases = (s.ov_phases & ~{3{clr1[S_OVER]}})
                     | (OVERVOLT_EVT ? OVERVOLT_PHASES : 3'h0);
    // peak capture at the end of each detection period
    if (CUR_PEAK_DONE) begin
      next_s.cpeak = {CUR_PEAK_PHASE, CUR_PEAK_VALUE};
    end
    if (VOLT_PEAK_DONE) begin
      next_s.voltage_peak_register = {VOLT_PEAK_PHASE, VOLT_PEAK_VALUE};
    end
    // history for change detection; a source switch may raise sign events on up to three phases
    next_s.prev_b30  = ENERGY_BIT30;
    next_s.prev_sign = sign_now;
    next_s.prev_sum  = PULSE1_SUM_SIGN;
    // one-cycle acknowledge with registered read data
    next_s.ack = go;
    next_s.dat = (go && !WB_WE_I) ? rd : 32'h0000_0000;
    // remembers which register the coming answer belongs to
    next_s.st1_rd = go && !WB_WE_I && idx == meter_irq_pkg::IDX_EVENT_STATUS_SECOND;
    // level interrupt from the flags as they will stand
    next_s.irq = |(next_s.stat0 & next_s.irq_enable_mask_low)
              || |(next_s.stat1 & next_s.mask1 & meter_irq_pkg::STAT1_LIVE);
  end

  // state register
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s <= '{irq_enable_mask_low: meter_irq_pkg::IRQ_ENABLE_MASK_LOW_RST, mask1: meter_irq_pkg::MASK1_RST,
             thresh: meter_irq_pkg::THRESH_RST, default: '0};
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign WB_DAT_O = s.dat;
  assign WB_ACK_O = s.ack;
  assign IRQ      = s.irq;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  // status read helper
  logic st1_rd; // acknowledged read of the second status register
  assign st1_rd = s.st1_rd;

  ov_flag_set_a: assert property (OVERVOLT_EVT |=> s.stat1[S_OVER]
    && ((s.ov_phases & $past(OVERVOLT_PHASES)) == $past(OVERVOLT_PHASES)))
    else $error("overvoltage flag or phase field not set");
  mis_flag_set_a: assert property (m.mismatch && HAS_NEUTRAL |=> s.stat1[S_MIS])
    else $error("mismatch flag not set");
  no_neutral_a: assert property (!HAS_NEUTRAL |-> !s.stat1[S_MIS])
    else $error("mismatch flag set without neutral channel");
  resv_one_a: assert property (st1_rd |-> WB_DAT_O[meter_irq_pkg::B_RES1])
    else $error("reserved bit 21 read as zero");
  resv_zero_a: assert property (st1_rd |-> !WB_DAT_O[meter_irq_pkg::B_RES0])
    else $error("reserved bit 22 read as one");
  upper_zero_a: assert property (st1_rd |-> WB_DAT_O[31:25] == 7'h00)
    else $error("status bits 31 to 25 not zero");
  cur_peak_a: assert property (CUR_PEAK_DONE |=> s.stat1[S_CPEAK]
    && s.cpeak == $past({CUR_PEAK_PHASE, CUR_PEAK_VALUE}))
    else $error("current peak not captured");
  volt_peak_a: assert property (VOLT_PEAK_DONE |=> s.stat1[S_VOLTAGE_PEAK_REGISTER]
    && s.voltage_peak_register == $past({VOLT_PEAK_PHASE, VOLT_PEAK_VALUE}))
    else $error("voltage peak not captured");
  tot_act_b30_a: assert property (ENERGY_BIT30[2:0] != s.prev_b30[2:0]
    |=> s.stat0[meter_irq_pkg::M_TOT_ACT])
    else $error("total active half full event lost");
  line_done_a: assert property (LINE_CYCLE_DONE && s.line_mode
    |=> s.stat0[meter_irq_pkg::M_LINE])
    else $error("line cycle event lost");
  irq_level_a: assert property (IRQ == (|(s.stat0 & s.irq_enable_mask_low) || |(s.stat1 & s.mask1)))
    else $error("interrupt level does not match flags");
  ack_one_a: assert property (s.ack |=> !s.ack)
    else $error("acknowledge held longer than one cycle");

  irq_rise_c: cover property (!IRQ ##1 IRQ);
  st1_read_c: cover property (st1_rd && WB_DAT_O[meter_irq_pkg::B_OVER]);
  w1c_clear_c: cover property (s.stat0 != 10'h000 ##1 s.stat0 == 10'h000);
endmodule : meter_event_irq

// [tb/metering_event_status_mask_tb.sv]
// self-checking bench for the metering event status and interrupt mask block
`timescale 1ns/1ps
module metering_event_status_mask_tb;
  // register word indices, short aliases of the package constants
  localparam logic [15:0] M0 = meter_irq_pkg::IDX_IRQ_ENABLE_MASK_LOW;
  localparam logic [15:0] S1 = meter_irq_pkg::IDX_EVENT_STATUS_SECOND;
  localparam logic [15:0] S0 = meter_irq_pkg::IDX_STATUS0;
  localparam logic [15:0] M1 = meter_irq_pkg::IDX_MASK1;
  localparam logic [15:0] PH = meter_irq_pkg::IDX_PHSTAT;
  localparam logic [15:0] TH = meter_irq_pkg::IDX_THRESH;
  localparam logic [15:0] AM = meter_irq_pkg::IDX_ACCUMULATION_MODE_REGISTER;
  localparam logic [31:0] R1 = 32'h0020_0000; // reserved bit 21 always reads one
  // clock, reset and bus drive
  logic        clk   = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [17:0] adr   = 18'h00000;
  logic [31:0] dat   = 32'h0;
  // event drive, all quiet at time zero
  logic        ov = 1'b0, cpd = 1'b0, vpd = 1'b0, vld = 1'b0, line = 1'b0, psum = 1'b0;
  logic [2:0]  ovph = 3'h0, zx = 3'h0, cph = 3'h0, vph = 3'h0, sgn = 3'h0, sgf = 3'h0;
  logic [23:0] summed_phase_current = 24'h0, ineu = 24'h0, cpv = 24'h0, vpv = 24'h0;
  logic [14:0] e30 = 15'h0;
  // design outputs
  logic [31:0] rdat;
  logic        ack;
  logic        irq;
  // scoreboard and counters
  logic [31:0] expq[$];
  int          num_errors  = 0;
  int          check_count = 0;
  int          seed        = 32'h7213;
  logic [31:0] r;

  // 250 MHz system clock
  always #2 clk = ~clk;

  meter_event_irq dut_u (
    .SYS_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_SEL_I(4'hF), .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .IRQ(irq), .OVERVOLT_EVT(ov), .OVERVOLT_PHASES(ovph), .ZERO_CROSS_RISE(zx),
    .SUM_CURRENT(summed_phase_current), .NEUTRAL_CURRENT(ineu), .CURRENT_SAMPLE_VALID(vld),
    .CUR_PEAK_DONE(cpd), .CUR_PEAK_VALUE(cpv), .CUR_PEAK_PHASE(cph),
    .VOLT_PEAK_DONE(vpd), .VOLT_PEAK_VALUE(vpv), .VOLT_PEAK_PHASE(vph),
    .ENERGY_BIT30(e30), .LINE_CYCLE_DONE(line), .ACTIVE_SIGN_TOTAL(sgn),
    .ACTIVE_SIGN_FUND(sgf), .PULSE1_SUM_SIGN(psum)
  );

  // single comparison point, four-state exact
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // summary and verdict, the only exit
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  // one classic cycle; a read leaves its expected word for the monitor
  task automatic wb(input logic w, input logic [15:0] idx, input logic [31:0] d);
    if (!w) expq.push_back(d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {idx, 2'b00};
    dat <= w ? d : 32'h0;
    // held until ack is sampled high, no latency assumed
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic irq_is(input logic v);
    chk({31'h0, irq}, {31'h0, v});
  endtask : irq_is

  // read answers are taken at the ack edge, oldest note first
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      chk(rdat, expq.size() > 0 ? expq.pop_front() : 32'hXXXX_XXXX);
    end
  end

  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #40000;
    num_errors++;
    final_report();
  end

  // main sequence
  initial begin
    tick(3);
    rst_n <= 1'b1;
    tick(1);
    irq_is(1'b0);
    wb(1'b0, M0, 32'h0);
    wb(1'b0, S1, R1);
    wb(1'b1, S1, 32'hFFFF_FFFF);
    wb(1'b0, S1, R1);
    wb(1'b1, M0, 32'hFFFF_FFFF);
    wb(1'b0, M0, 32'h0000_03FF);
    $display("test reset and reserved done");
    // overvoltage on phase b, masked first
    ov   <= 1'b1;
    ovph <= 3'b010;
    tick(1);
    ov <= 1'b0;
    tick(1);
    wb(1'b0, S1, 32'h0024_0000);
    wb(1'b0, PH, 32'h0000_0400);
    irq_is(1'b0);
    wb(1'b1, M1, 32'h01FC_0000);
    irq_is(1'b1);
    wb(1'b1, S1, 32'h0004_0000);
    irq_is(1'b0);
    wb(1'b0, PH, 32'h0);
    $display("test overvoltage done");
    // a then b is proper rotation, a then c is not
    for (int k = 1; k < 3; k++) begin
      zx <= 3'b001;
      tick(1);
      zx <= 3'b001 << k;
      tick(1);
      zx <= 3'b000;
      tick(3);
      wb(1'b0, S1, R1 | ((k - 1) << 19));
    end
    irq_is(1'b1);
    wb(1'b1, S1, 32'h0008_0000);
    $display("test sequence done");
    // margin equal to threshold, then one above
    r = $random(seed) & 32'h0000_FFFF;
    wb(1'b1, TH, r);
    for (int k = 0; k < 2; k++) begin
      summed_phase_current <= r[23:0] + 24'h2 + k;
      ineu <= 24'hFFFFFE;
      vld  <= 1'b1;
      tick(1);
      vld <= 1'b0;
      tick(3);
      wb(1'b0, S1, R1 | (k << 20));
    end
    wb(1'b1, S1, 32'h0010_0000);
    $display("test mismatch done");
    // both peak periods end together
    r   = $random(seed);
    cpv <= r[23:0];
    cph <= r[26:24];
    vpv <= ~r[23:0];
    vph <= r[30:28];
    cpd <= 1'b1;
    vpd <= 1'b1;
    tick(1);
    cpd <= 1'b0;
    vpd <= 1'b0;
    tick(1);
    wb(1'b0, S1, 32'h01A0_0000);
    wb(1'b0, meter_irq_pkg::IDX_CURPEAK, {5'h0, r[26:24], r[23:0]});
    wb(1'b0, meter_irq_pkg::IDX_VOLTPEAK, {5'h0, r[30:28], ~r[23:0]});
    wb(1'b1, S1, 32'hFFFF_FFFF);
    $display("test peaks done");
    // each energy kind on one phase, going through a, b and c in turn
    for (int k = 0; k < 5; k++) begin
      e30 <= e30 ^ (15'h1 << (k * 3 + k % 3));
      tick(2);
      wb(1'b0, S0, 32'h1 << k);
      irq_is(1'b1);
      wb(1'b1, S0, 32'h1 << k);
      irq_is(1'b0);
    end
    // line cycle end ignored outside line mode
    for (int k = 0; k < 2; k++) begin
      wb(1'b1, AM, k);
      line <= 1'b1;
      tick(1);
      line <= 1'b0;
      tick(1);
      wb(1'b0, S0, k << 5);
    end
    wb(1'b1, S0, 32'h20);
    // sign flips per phase; the pulse-one sum follows the source switch
    for (int k = 0; k < 3; k++) begin
      sgn <= sgn ^ (3'b001 << k);
      tick(2);
      wb(1'b0, S0, 32'h40 << k);
      wb(1'b1, S0, 32'h40 << k);
    end
    // switch to the fundamental source with equal signs, then only it counts
    sgf <= 3'b111;
    wb(1'b1, AM, 32'h41);
    sgn <= sgn ^ 3'b001;
    sgf <= 3'b101;
    tick(2);
    wb(1'b0, S0, 32'h80);
    wb(1'b1, S0, 32'h80);
    psum <= 1'b1;
    tick(2);
    wb(1'b0, S0, 32'h200);
    // masked event is recorded but raises nothing
    wb(1'b1, M0, 32'h0);
    e30 <= e30 ^ 15'h1;
    tick(2);
    wb(1'b0, S0, 32'h201);
    irq_is(1'b0);
    $display("test energy and sign done");
    final_report();
  end
endmodule : metering_event_status_mask_tb
